// ==== ssp_pkg.sv ====
/*
  Shared constants, field positions and state codes for the synchronous serial port core.
  Assumes a single 125 MHz system clock and a design compiled after this package.
*/
`default_nettype none
package ssp_pkg;
  localparam int unsigned     FIFO_W        = 16;
  localparam int unsigned     FIFO_D        = 8;
  localparam int unsigned     PTR_W         = 3;
  localparam int unsigned     CNT_W         = 4;
  localparam logic [3:0]      HALF_LEVEL    = 4'h4;
  localparam logic [3:0]      WIDTH_MIN_M1  = 4'h3;
  localparam logic [3:0]      WIDTH_MAX_M1  = 4'hf;
  localparam logic [6:0]      PSC_HALF_MIN  = 7'h01;
  localparam int unsigned     SYS_CLK_HZ    = 125_000_000;
  localparam int unsigned     NOMINAL_HZ    = 50_000_000;
  localparam int unsigned     MIN_RATE_HZ   = 2_000_000;
  localparam int unsigned     MASTER_RATIO  = 2;
  localparam int unsigned     SLAVE_RATIO   = 12;
  localparam int unsigned     TIMEOUT_BITS  = 32;
  localparam logic [6:0]      TIMEOUT_HALF  = 7'((2 * TIMEOUT_BITS) & 8'h7f);
  localparam int unsigned     ST_TXS        = 0;
  localparam int unsigned     ST_RXS        = 1;
  localparam int unsigned     ST_RTO        = 2;
  localparam int unsigned     ST_OVR        = 3;
  localparam logic [3:0]      STATUS_RESET  = 4'h0;
  localparam logic [15:0]     ONES16        = 16'hffff;

  typedef enum logic [2:0] {
    SSP_IDLE  = 3'b000,
    SSP_LEAD  = 3'b001,
    SSP_HIGH  = 3'b011,
    SSP_LOW   = 3'b111,
    SSP_TRAIL = 3'b010
  } ssp_state_e;
endpackage : ssp_pkg
`default_nettype wire

// ==== ssp_fifo.sv ====
/*
  Eight-entry, sixteen-bit first-in first-out store with registered head data.
  Assumes the clock and synchronised reset of the port core.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              in_valid,
  input  wire logic [FIFO_W-1:0] in_data,
  output logic                   in_ready,
  output logic                   out_valid,
  output logic [FIFO_W-1:0]      out_data,
  input  wire logic              out_ready,
  output logic [CNT_W-1:0]       count
);
  logic [FIFO_W-1:0] mem_q [FIFO_D];
  logic [PTR_W-1:0]  wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              rdy_q, vld_q;
  logic [FIFO_W-1:0] head_q, head_d;
  logic              push, pop;

  always_comb begin
    push = in_valid && rdy_q;
    pop  = out_ready && vld_q;
    wr_d = push ? wr_q + 3'h1 : wr_q;
    rd_d = pop ? rd_q + 3'h1 : rd_q;
    cnt_d = cnt_q + {3'h0, push} - {3'h0, pop};
    // Bypass keeps the head correct when a word lands in the slot being read.
    head_d = (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      rdy_q  <= 1'b1;
      vld_q  <= 1'b0;
      head_q <= '0;
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      rdy_q  <= cnt_d != CNT_W'(FIFO_D);
      vld_q  <= cnt_d != '0;
      head_q <= head_d;
    end
  end

  assign in_ready  = rdy_q;
  assign out_valid = vld_q;
  assign out_data  = head_q;
  assign count     = cnt_q;

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q == 4'h8 |-> !rdy_q) else $error("full store still accepts words");
endmodule : ssp_fifo
`default_nettype wire

// ==== ssp_skid.sv ====
/*
  Two-entry buffer with valid and ready on both sides; all outputs are registered.
  Assumes the clock and synchronised reset of the port core.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_skid
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              in_valid,
  input  wire logic [FIFO_W-1:0] in_data,
  output logic                   in_ready,
  output logic                   out_valid,
  output logic [FIFO_W-1:0]      out_data,
  input  wire logic              out_ready
);
  logic              ov_q, ov_d, sv_q, sv_d, rdy_q;
  logic [FIFO_W-1:0] od_q, od_d, sd_q, sd_d;
  logic              take;

  always_comb begin
    take = in_valid && rdy_q;
    ov_d = ov_q;
    od_d = od_q;
    sv_d = sv_q;
    sd_d = sd_q;
    if (ov_q && !out_ready) begin
      if (take) begin
        sd_d = in_data;
        sv_d = 1'b1;
      end
    end else if (sv_q) begin
      od_d = sd_q;
      ov_d = 1'b1;
      sv_d = take;
      if (take) begin
        sd_d = in_data;
      end
    end else begin
      ov_d = take;
      if (take) begin
        od_d = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_q  <= 1'b0;
      sv_q  <= 1'b0;
      od_q  <= '0;
      sd_q  <= '0;
      rdy_q <= 1'b1;
    end else begin
      ov_q  <= ov_d;
      sv_q  <= sv_d;
      od_q  <= od_d;
      sd_q  <= sd_d;
      rdy_q <= !sv_d;
    end
  end

  assign in_ready  = rdy_q;
  assign out_valid = ov_q;
  assign out_data  = od_q;

  skid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ov_q && !out_ready |=> ov_q && $stable(od_q)) else $error("stalled word changed");
endmodule : ssp_skid
`default_nettype wire

// ==== ssp_core.sv ====
/*
  Synchronous serial port core: divider, master and slave shifters, buffers and events.
  Assumes control inputs held steady during frames and pins driven by the board through
  the enables given here.
*/
// Operation
// - Port runs as serial clock master or as slave of an outside master.
// - Frame width is programmable from 4 to 16 bits.
// - Loopback returns transmitted bits to the receive shifter.
// - First divider stage divides by an even prescale from 2 to 254.
// - Second stage divides by one plus the serial clock rate field.
// - Bit clock equals system clock over prescale times rate plus one.
// - Divider settings reach bit rates of 2 MHz and above.
// - Master divider keeps system clock at least twice the bit clock.
// - Transmit store holds eight 16-bit words until shifted out.
// - A data write pushes the word into the transmit store.
// - Words from the transmit store are shifted out in both roles.
// - Receive store holds eight 16-bit words; a data read pops oldest.
// - Received bits fill the shifter, then load whole into the receive store.
// - Four events: transmit service, receive service, timeout and overrun.
// - All events are ORed into one interrupt request.
// - Each event has a mask bit; one lets it reach the request.
// - Bit clock rests inactive when idle and toggles only during frames.
// - Timeout rises after a quiet bit clock while the receive store, not the two-entry read buffer, holds words.
// - Frames go out most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module ssp_core
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              port_enable,
  input  wire logic              master_mode,
  input  wire logic              loopback,
  input  wire logic [3:0]        frame_size_m1,
  input  wire logic [7:0]        clock_prescale_divisor,
  input  wire logic [7:0]        serial_clock_rate_field,
  input  wire logic [3:0]        interrupt_mask,
  input  wire logic              overrun_clear,
  input  wire logic              wr_valid,
  input  wire logic [FIFO_W-1:0] wr_data,
  output logic                   wr_ready,
  output logic                   rd_valid,
  output logic [FIFO_W-1:0]      rd_data,
  input  wire logic              rd_ready,
  output logic [3:0]             raw_status,
  output logic [3:0]             masked_status,
  output logic                   irq,
  input  wire logic              serial_bit_clock_i,
  output logic                   serial_bit_clock_o,
  output logic                   serial_bit_clock_oe,
  input  wire logic              frame_select_line_n_i,
  output logic                   frame_select_line_n_o,
  output logic                   frame_select_line_n_oe,
  output logic                   serial_transmit_line_o,
  output logic                   serial_transmit_line_oe,
  input  wire logic              serial_receive_line
);
  logic [1:0]        rs_q;
  logic              rst_n;
  logic [2:0]        s1_q, s2_q;
  logic [1:0]        s3_q;
  ssp_state_e        st_q, st_d;
  logic [6:0]        pre_q, pre_d;
  logic [7:0]        scr_q, scr_d;
  logic [15:0]       tsh_q, tsh_d, rsh_q, rsh_d;
  logic [3:0]        bit_q, bit_d;
  logic              sclk_q, sclk_d, fss_q, fss_d, txd_q, txd_d, slv_q, slv_d;
  logic [6:0]        to_q, to_d;
  logic [3:0]        raw_q, raw_d, mis_q, mis_d;
  logic              irq_q, irq_d, sck_oe_q, fss_oe_q, txoe_q, txoe_d;
  logic [6:0]        psc_half;
  logic              pre_tick, half_tick, rx_bit, s_rise, s_fall, s_start, s_sel;
  logic [3:0]        wm1;
  logic [15:0]       mask16, tx_load;
  logic              tx_valid, tx_pop, rx_push, rx_in_ready, rxf_valid, rxf_pop;
  logic [15:0]       tx_word, rxf_data;
  logic [3:0]        tx_count, rx_count;

  // Reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  // Pins from the far side pass two flops; the third stage only feeds edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h2;
      s2_q <= 3'h2;
      s3_q <= 2'h2;
    end else begin
      s1_q <= {serial_receive_line, frame_select_line_n_i, serial_bit_clock_i};
      s2_q <= s1_q;
      s3_q <= s2_q[1:0];
    end
  end

  ssp_fifo u_txf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (tx_valid),
    .out_data  (tx_word),
    .out_ready (tx_pop),
    .count     (tx_count)
  );

  ssp_fifo u_rxf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_data   (rsh_d & mask16),
    .in_ready  (rx_in_ready),
    .out_valid (rxf_valid),
    .out_data  (rxf_data),
    .out_ready (rxf_pop),
    .count     (rx_count)
  );

  // A stalled reader holds words in this buffer instead of losing them.
  ssp_skid u_rd (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rxf_valid),
    .in_data   (rxf_data),
    .in_ready  (rxf_pop),
    .out_valid (rd_valid),
    .out_data  (rd_data),
    .out_ready (rd_ready)
  );

  always_comb begin
    wm1 = (frame_size_m1 < WIDTH_MIN_M1) ? WIDTH_MIN_M1 : frame_size_m1;
    mask16 = ONES16 >> (WIDTH_MAX_M1 - wm1);
    tx_load = tx_word << (WIDTH_MAX_M1 - wm1);
    // Half of an even prescale; the low bit is ignored so odd values round down.
    psc_half = (clock_prescale_divisor[7:1] == 7'h0) ? PSC_HALF_MIN
             : clock_prescale_divisor[7:1];
    pre_tick = pre_q == psc_half - 7'h1;
    half_tick = pre_tick && scr_q == serial_clock_rate_field;
    pre_d = pre_tick ? 7'h0 : pre_q + 7'h1;
    scr_d = scr_q;
    if (half_tick) begin
      scr_d = 8'h0;
    end else if (pre_tick) begin
      scr_d = scr_q + 8'h1;
    end
    s_sel   = !s2_q[1];
    s_start = s3_q[1] && !s2_q[1];
    s_rise  = !s3_q[0] && s2_q[0];
    s_fall  = s3_q[0] && !s2_q[0];
    rx_bit  = loopback ? txd_q : s2_q[2];
  end

  always_comb begin
    st_d = st_q;
    tsh_d = tsh_q;
    rsh_d = rsh_q;
    bit_d = bit_q;
    sclk_d = sclk_q;
    fss_d = fss_q;
    txd_d = txd_q;
    slv_d = slv_q;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    txoe_d = 1'b0;
    if (port_enable && master_mode) begin
      txoe_d = 1'b1;
      unique case (st_q)
        SSP_IDLE: begin
          sclk_d = 1'b0;
          fss_d = 1'b1;
          if (half_tick && tx_valid) begin
            tx_pop = 1'b1;
            tsh_d = tx_load;
            txd_d = tx_load[15];
            fss_d = 1'b0;
            bit_d = 4'h0;
            st_d = SSP_LEAD;
          end
        end
        SSP_LEAD, SSP_LOW: begin
          if (half_tick) begin
            sclk_d = 1'b1;
            rsh_d = {rsh_q[14:0], rx_bit};
            st_d = SSP_HIGH;
          end
        end
        SSP_HIGH: begin
          if (half_tick) begin
            sclk_d = 1'b0;
            if (bit_q == wm1) begin
              rx_push = 1'b1;
              st_d = SSP_TRAIL;
            end else begin
              bit_d = bit_q + 4'h1;
              tsh_d = {tsh_q[14:0], 1'b0};
              txd_d = tsh_q[14];
              st_d = SSP_LOW;
            end
          end
        end
        SSP_TRAIL: begin
          if (half_tick) begin
            fss_d = 1'b1;
            st_d = SSP_IDLE;
          end
        end
        default: begin
          st_d = SSP_IDLE;
        end
      endcase
    end else begin
      st_d = SSP_IDLE;
      sclk_d = 1'b0;
      fss_d = 1'b1;
      // Slave edges are seen two flops late, hence the limit on the outside clock rate.
      if (port_enable && s_start) begin
        tx_pop = tx_valid;
        tsh_d = tx_valid ? tx_load : 16'h0;
        txd_d = tx_valid ? tx_load[15] : 1'b0;
        bit_d = 4'h0;
        slv_d = 1'b1;
      end else if (port_enable && s_sel && slv_q) begin
        txoe_d = 1'b1;
        if (s_rise) begin
          rsh_d = {rsh_q[14:0], rx_bit};
          if (bit_q == wm1) begin
            rx_push = 1'b1;
            slv_d = 1'b0;
          end
        end else if (s_fall) begin
          bit_d = bit_q + 4'h1;
          tsh_d = {tsh_q[14:0], 1'b0};
          txd_d = tsh_q[14];
        end
      end else if (!s_sel) begin
        slv_d = 1'b0;
      end
    end
  end

  always_comb begin
    to_d = to_q;
    if (rx_count == 4'h0 || st_q != SSP_IDLE || (s_sel && !master_mode)) begin
      to_d = 7'h0;
    end else if (half_tick && to_q != TIMEOUT_HALF) begin
      to_d = to_q + 7'h1;
    end
    raw_d[ST_TXS] = tx_count <= HALF_LEVEL;
    raw_d[ST_RXS] = rx_count >= HALF_LEVEL;
    // The store may drain while the count still stands, so the flag also needs data held.
    raw_d[ST_RTO] = (to_q == TIMEOUT_HALF) && (rx_count != 4'h0);
    // A new overrun wins over a clear in the same cycle.
    raw_d[ST_OVR] = (rx_push && !rx_in_ready)
                  || (raw_q[ST_OVR] && !overrun_clear);
    mis_d = raw_d & interrupt_mask;
    irq_d = |mis_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SSP_IDLE;
      pre_q <= 7'h0;
      scr_q <= 8'h0;
      tsh_q <= 16'h0;
      rsh_q <= 16'h0;
      bit_q <= 4'h0;
      sclk_q <= 1'b0;
      fss_q <= 1'b1;
      txd_q <= 1'b0;
      slv_q <= 1'b0;
      txoe_q <= 1'b0;
      sck_oe_q <= 1'b0;
      fss_oe_q <= 1'b0;
      to_q <= 7'h0;
      raw_q <= STATUS_RESET;
      mis_q <= STATUS_RESET;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      scr_q <= scr_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      bit_q <= bit_d;
      sclk_q <= sclk_d;
      fss_q <= fss_d;
      txd_q <= txd_d;
      slv_q <= slv_d;
      txoe_q <= txoe_d;
      sck_oe_q <= port_enable && master_mode;
      fss_oe_q <= port_enable && master_mode;
      to_q <= to_d;
      raw_q <= raw_d;
      mis_q <= mis_d;
      irq_q <= irq_d;
    end
  end

  assign serial_bit_clock_o = sclk_q;
  assign serial_bit_clock_oe = sck_oe_q;
  assign frame_select_line_n_o = fss_q;
  assign frame_select_line_n_oe = fss_oe_q;
  assign serial_transmit_line_o = txd_q;
  assign serial_transmit_line_oe = txoe_q;
  assign raw_status = raw_q;
  assign masked_status = mis_q;
  assign irq = irq_q;

  idle_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st_q) == SSP_IDLE && st_q == SSP_IDLE |-> !sclk_q) else $error("clock moved idle");
  irq_or_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_q == |(raw_q & $past(interrupt_mask))) else $error("request not OR of masked events");
  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    mis_q == (raw_q & $past(interrupt_mask))) else $error("mask not applied");
  overrun_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push && !rx_in_ready |=> raw_q[ST_OVR]) else $error("overrun missed");
  tx_service_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> raw_q[ST_TXS] == ($past(tx_count) <= 4'h4))
    else $error("transmit service wrong");
  rx_service_a: assert property (@(posedge clk) disable iff (!rst_n)
    raw_q[ST_RXS] == ($past(rx_count) >= 4'h4)) else $error("receive service wrong");
  frame_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push && master_mode |-> bit_q == wm1) else $error("frame length wrong");
  frame_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == SSP_IDLE && st_d == SSP_LEAD |=> !fss_q && txd_q == $past(tx_load[15])) else $error("frame start wrong");
  timeout_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rx_count) == 4'h0 |-> !raw_q[ST_RTO]) else $error("timeout with empty store");
endmodule : ssp_core
`default_nettype wire

// ==== ssp_peer_model.sv ====
/*
  Behavioural model of an outside serial peripheral, clock polarity 0 and phase 0.
  Assumes the port core drives clock and active-low select; replies base plus frame number.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_model (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [15:0] reply_base,
  input  wire logic [3:0]  width_m1,
  output logic             miso,
  output logic [15:0]      got,
  output logic [7:0]       frames
);
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  int          nbit;

  initial begin
    frames = 8'h00;
    miso   = 1'b0;
    got    = 16'h0000;
    rx_sh  = 16'h0000;
    nbit   = 0;
  end

  // A new reply per frame, so a dropped or repeated word shows in the data.
  always @(negedge sel_n) begin
    tx_sh = reply_base + 16'(frames);
    nbit  = 0;
    rx_sh = 16'h0000;
    miso  = tx_sh[width_m1];
  end

  always @(posedge sclk) begin
    if (!sel_n) begin
      rx_sh = {rx_sh[14:0], mosi};
      nbit++;
    end
  end

  always @(negedge sclk) begin
    if (!sel_n && nbit <= int'(width_m1)) begin
      miso = tx_sh[int'(width_m1) - nbit];
    end
  end

  // The line is not pulled, so after release it shows the inverse of its last bit.
  always @(posedge sel_n) begin
    got  = rx_sh;
    frames++;
    miso = ~miso;
  end
endmodule : ssp_peer_model
`default_nettype wire

// ==== tb.sv ====
/*
  Self-checking bench for the serial port core: divider, framing, loopback, slave role,
  buffers and events.
  Assumes the peer model on the pins in master role; the bench is the outside master otherwise.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssp_pkg::*;
  logic        clk, reset_n, port_enable, master_mode, loopback, overrun_clear;
  logic [3:0]  frame_size_m1, interrupt_mask, raw_status, masked_status;
  logic [7:0]  clock_prescale_divisor, serial_clock_rate_field, frames, f0;
  logic        wr_valid, wr_ready, rd_valid, rd_ready, irq, peer_miso, tb_sclk, tb_fss_n, tb_mosi;
  logic [15:0] wr_data, rd_data, reply_base, got, d, sin, mask;
  logic        sclk_o, sclk_oe, fss_o, fss_oe, txd_o, txd_oe, sclk_d;
  int          error_cnt, samples_checked, cyc, last_rise, period, rise_cnt, r0;
  logic [7:0]  ps_t [3]  = '{8'h06, 8'h02, 8'h04};
  logic [7:0]  scr_t [3] = '{8'h01, 8'h05, 8'h03};
  logic [3:0]  m1_t [3]  = '{4'hf, 4'h3, 4'h7};
  logic [15:0] tx_t [3]  = '{16'ha5c3, 16'h000b, 16'h0096};
  logic [15:0] per_t [3] = '{16'h000c, 16'h000c, 16'h0010};
  wire         sclk_w = sclk_oe ? sclk_o : tb_sclk;
  wire         fss_w  = fss_oe ? fss_o : tb_fss_n;
  wire         rxd_w  = master_mode ? peer_miso : tb_mosi;

  ssp_core u_ssp_core (
    .clk(clk), .reset_n(reset_n), .port_enable(port_enable), .master_mode(master_mode),
    .loopback(loopback), .frame_size_m1(frame_size_m1),
    .clock_prescale_divisor(clock_prescale_divisor),
    .serial_clock_rate_field(serial_clock_rate_field), .interrupt_mask(interrupt_mask),
    .overrun_clear(overrun_clear), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .raw_status(raw_status), .masked_status(masked_status), .irq(irq),
    .serial_bit_clock_i(sclk_w), .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe(sclk_oe),
    .frame_select_line_n_i(fss_w), .frame_select_line_n_o(fss_o),
    .frame_select_line_n_oe(fss_oe), .serial_transmit_line_o(txd_o),
    .serial_transmit_line_oe(txd_oe), .serial_receive_line(rxd_w));

  ssp_peer_model u_ssp_peer_model (
    .sclk(sclk_w), .sel_n(fss_w), .mosi(txd_o), .reply_base(reply_base),
    .width_m1(frame_size_m1), .miso(peer_miso), .got(got), .frames(frames));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Rising edges of the bit clock are timed here; the hang limit lives here as well.
  always @(negedge clk) begin
    cyc++;
    if (sclk_o === 1'b1 && sclk_d === 1'b0) begin
      period = cyc - last_rise;
      last_rise = cyc;
      rise_cnt++;
    end
    sclk_d = sclk_o;
    if (cyc > 30000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic wr_word(input logic [15:0] w);
    wr_valid = 1'b1;
    wr_data = w;
    while (wr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
    @(negedge clk);
  endtask : wr_word

  task automatic rd_word(output logic [15:0] r);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) chk(16'(rd_valid), 16'h1);
    r = rd_data;
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
    @(negedge clk);
  endtask : rd_word

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    logic [7:0] fs;
    int         n;
    fs = frames;
    n = 0;
    wr_word(w);
    rd_word(r);
    while (frames == fs && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask : xfer

  // Outside master of eight bits, half period six system cycles.
  task automatic slv_frame(input logic [7:0] o, output logic [15:0] s);
    s = 16'h0000;
    tb_fss_n = 1'b0;
    repeat (12) @(negedge clk);
    for (int b = 7; b >= 0; b--) begin
      tb_mosi = o[b];
      repeat (6) @(negedge clk);
      tb_sclk = 1'b1;
      s = {s[14:0], txd_o & txd_oe};
      repeat (6) @(negedge clk);
      tb_sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    tb_fss_n = 1'b1;
    tb_mosi = ~tb_mosi;
    repeat (12) @(negedge clk);
  endtask : slv_frame

  initial begin
    {error_cnt, samples_checked, cyc, last_rise, period, rise_cnt} = '0;
    reset_n = 1'b0; port_enable = 1'b1; master_mode = 1'b1; loopback = 1'b0;
    frame_size_m1 = 4'hf; clock_prescale_divisor = 8'h04; serial_clock_rate_field = 8'h01;
    interrupt_mask = 4'h0; overrun_clear = 1'b0; wr_valid = 1'b0; wr_data = 16'h0000;
    rd_ready = 1'b0; tb_sclk = 1'b0; tb_fss_n = 1'b1; tb_mosi = 1'b0; sclk_d = 1'b0;
    reply_base = 16'h3c5a;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(wr_ready), 16'h1);
    chk(16'(raw_status), 16'h1);
    chk(16'(fss_o), 16'h1);
    chk(16'(sclk_oe), 16'h1);
    chk(16'({fss_oe, txd_oe}), 16'h3);
    for (int i = 0; i < 3; i++) begin
      clock_prescale_divisor = ps_t[i];
      serial_clock_rate_field = scr_t[i];
      frame_size_m1 = m1_t[i];
      mask = ONES16 >> (4'hf - m1_t[i]);
      sin = (reply_base + 16'(frames)) & mask;
      xfer(tx_t[i], d);
      chk(d, sin);
      chk(got, tx_t[i] & mask);
      chk(16'(period), per_t[i]);
    end
    loopback = 1'b1;
    xfer(16'h00c3, d);
    chk(d, 16'h00c3);
    loopback = 1'b0;
    master_mode = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(sclk_oe), 16'h0);
    chk(16'({fss_oe, txd_oe}), 16'h0);
    wr_word(16'h005a);
    slv_frame(8'ha6, sin);
    rd_word(d);
    chk(sin, 16'h005a);
    chk(d, 16'h00a6);
    master_mode = 1'b1;
    frame_size_m1 = 4'hf;
    clock_prescale_divisor = 8'h04;
    serial_clock_rate_field = 8'h01;
    port_enable = 1'b0;
    f0 = frames;
    for (int k = 0; k < 8; k++) wr_word(16'h0100 + 16'(k));
    repeat (3) @(negedge clk);
    chk(16'(wr_ready), 16'h0);
    chk(16'(raw_status[ST_TXS]), 16'h0);
    port_enable = 1'b1;
    for (int k = 8; k < 11; k++) wr_word(16'h0100 + 16'(k));
    r0 = 0;
    while (frames != 8'(f0 + 8'd11) && r0 < 8000) begin
      @(negedge clk);
      r0++;
    end
    chk(got, 16'h010a);
    repeat (4) @(negedge clk);
    chk(16'(raw_status & 4'hb), 16'h000b);
    interrupt_mask = 4'h8;
    repeat (4) @(negedge clk);
    chk(16'(irq), 16'h1);
    chk(16'(masked_status), 16'h8);
    interrupt_mask = 4'h0;
    repeat (4) @(negedge clk);
    chk(16'(irq), 16'h0);
    r0 = rise_cnt;
    repeat (300) @(negedge clk);
    chk(16'(raw_status[ST_RTO]), 16'h1);
    chk(16'(rise_cnt - r0), 16'h0);
    for (int k = 0; k < 10; k++) begin
      rd_word(d);
      chk(d, reply_base + 16'(f0) + 16'(k));
    end
    repeat (3) @(negedge clk);
    chk(16'(rd_valid), 16'h0);
    overrun_clear = 1'b1;
    @(negedge clk);
    overrun_clear = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'(raw_status), 16'h1);
    conclude();
  end
endmodule : tb
`default_nettype wire
